// >>> cbbc_core.sv
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "cbbc_defines.svh"

// ==========================================================================
module cbbc_core (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  // instruction request
  input  wire logic                   instr_valid,
  input  wire cbbc_pkg::cbbc_instr_s  instr,
  output logic                        busy,
  output logic                        done,
  output logic                        taken,
  output logic                        refused,
  // data memory port
  output var  cbbc_pkg::cbbc_mem_req_s mem_req,
  input  wire logic [15:0]            mem_rdata,
  // register port
  input  wire logic [3:0]             reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [15:0]                 reg_rdata,
  // core state
  output logic [15:0]                 prog_ctr,
  output logic [15:0]                 stat_word
);

  // ========================================================================
  // decode helpers
  function automatic logic [15:0] sext7(input logic [6:0] ofs);
    sext7 = {{9{ofs[6]}}, ofs};
  endfunction : sext7

  function automatic logic is_alias(input cbbc_pkg::cbbc_cond_e cond);
    is_alias = (cond == cbbc_pkg::cbbc_cc_uns_not_under) ||
               (cond == cbbc_pkg::cbbc_cc_uns_under) ||
               (cond == cbbc_pkg::cbbc_cc_uns_above) ||
               (cond == cbbc_pkg::cbbc_cc_uns_atmost);
  endfunction : is_alias

  // undefined codes 4'he and 4'hf are refused like a disabled alias
  function automatic logic cond_legal(input cbbc_pkg::cbbc_cond_e cond,
                                      input logic                 cc_mode);
    cond_legal = (cond <= cbbc_pkg::cbbc_cc_uns_atmost) && (cc_mode || !is_alias(cond));
  endfunction : cond_legal

  function automatic logic cond_true(input cbbc_pkg::cbbc_cond_e cond,
                                     input logic [15:0]          s);
    logic c;
    logic z;
    logic nv;
    logic nrm;
    c   = s[`CBBC_STAT_C];
    z   = s[`CBBC_STAT_Z];
    nv  = s[`CBBC_STAT_N] ^ s[`CBBC_STAT_V];
    nrm = z | (!s[`CBBC_STAT_U] & !s[`CBBC_STAT_E]);
    case (cond)
      cbbc_pkg::cbbc_cc_carry_clr,
      cbbc_pkg::cbbc_cc_uns_not_under: cond_true = !c;
      cbbc_pkg::cbbc_cc_carry_set,
      cbbc_pkg::cbbc_cc_uns_under:     cond_true = c;
      cbbc_pkg::cbbc_cc_zero_set:      cond_true = z;
      cbbc_pkg::cbbc_cc_zero_clear:    cond_true = !z;
      cbbc_pkg::cbbc_cc_signed_atleast: cond_true = !nv;
      cbbc_pkg::cbbc_cc_signed_under:  cond_true = nv;
      cbbc_pkg::cbbc_cc_signed_above:  cond_true = !(z | nv);
      cbbc_pkg::cbbc_cc_signed_atmost: cond_true = z | nv;
      cbbc_pkg::cbbc_cc_not_normal:    cond_true = !nrm;
      cbbc_pkg::cbbc_cc_normal:        cond_true = nrm;
      cbbc_pkg::cbbc_cc_uns_above:     cond_true = !c & !z;
      cbbc_pkg::cbbc_cc_uns_atmost:    cond_true = c | z;
      default:                         cond_true = 1'b0;
    endcase
  endfunction : cond_true

  // ========================================================================
  // state
  cbbc_pkg::cbbc_st_s st_r;
  cbbc_pkg::cbbc_st_s st_nxt;

  logic        take;
  logic        is_br;
  logic        br_ok;
  logic        br_legal;
  logic [15:0] br_tgt;
  logic [15:0] take_mask;

  assign take      = instr_valid && (st_r.state == cbbc_pkg::cbbc_idle);
  assign is_br     = (instr.op == cbbc_pkg::cbbc_op_branch);
  assign br_legal  = cond_legal(instr.cond, st_r.opmode[`CBBC_OPMODE_CC]);
  assign br_ok     = br_legal && cond_true(instr.cond, st_r.stat_word);
  // base is the word after the branch
  assign br_tgt    = st_r.pc + `CBBC_WORDS_BR + sext7(instr.offset);
  assign take_mask = instr.mask;

  // ========================================================================
  // next state
  always_comb begin
    st_nxt               = st_r;
    st_nxt.done          = 1'b0;
    st_nxt.mem.rd        = 1'b0;
    st_nxt.mem.wr        = 1'b0;
    st_nxt.reg_rdata     = 16'h0000;

    // read data stands only in the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        `CBBC_OFS_PROG_CTR:  st_nxt.reg_rdata = st_r.pc;
        `CBBC_OFS_STAT_WORD: st_nxt.reg_rdata = st_r.stat_word;
        `CBBC_OFS_OPMODE:    st_nxt.reg_rdata = st_r.opmode;
        `CBBC_OFS_EXEC_STAT: begin
          st_nxt.reg_rdata[`CBBC_XST_TAKEN]   = st_r.taken;
          st_nxt.reg_rdata[`CBBC_XST_REFUSED] = st_r.refused;
          st_nxt.reg_rdata[`CBBC_XST_BUSY]    = st_r.busy;
        end
        default:             st_nxt.reg_rdata = 16'h0000;
      endcase
    end

    // software writes to pc lose against any instruction finishing in the same cycle, to status word only against a bit invert
    if (reg_wr) begin
      case (reg_addr)
        `CBBC_OFS_PROG_CTR:  st_nxt.pc        = reg_wdata;
        `CBBC_OFS_STAT_WORD: st_nxt.stat_word = reg_wdata;
        `CBBC_OFS_OPMODE:    st_nxt.opmode    = reg_wdata;
        default:             st_nxt.opmode    = st_r.opmode;
      endcase
    end

    case (st_r.state)
      cbbc_pkg::cbbc_idle: begin
        if (instr_valid) begin
          st_nxt.state       = cbbc_pkg::cbbc_run;
          st_nxt.busy        = 1'b1;
          st_nxt.op          = instr.op;
          st_nxt.dest_status = instr.dest_status;
          st_nxt.mask        = instr.mask;
          st_nxt.taken       = 1'b0;
          st_nxt.refused     = 1'b0;
          if (is_br) begin
            st_nxt.taken   = br_ok;
            st_nxt.refused = !br_legal;
            if (br_ok) begin
              st_nxt.next_pc = br_tgt;
              st_nxt.cnt     = 3'(`CBBC_CYC_BR_TAKEN - 3'h1);
            end else begin
              st_nxt.next_pc = st_r.pc + `CBBC_WORDS_BR;
              st_nxt.cnt     = 3'(`CBBC_CYC_BR_FALL - 3'h1);
            end
          end else begin
            st_nxt.next_pc = st_r.pc + `CBBC_WORDS_BITINV;
            st_nxt.cnt     = 3'(`CBBC_CYC_BITINV - 3'h1);
            if (!instr.dest_status) begin
              st_nxt.mem.rd   = 1'b1;
              st_nxt.mem.addr = instr.addr;
            end
          end
        end
      end
      cbbc_pkg::cbbc_run: begin
        if ((st_r.cnt == 3'h2) && (st_r.op == cbbc_pkg::cbbc_op_bitinv) &&
            !st_r.dest_status) begin
          // all selected bits one, zero mask counts as all one
          st_nxt.carry_new = &(mem_rdata | ~st_r.mask);
          // invert selected bits, write back; single write
          st_nxt.mem.wr    = 1'b1;
          st_nxt.mem.wdata = mem_rdata ^ st_r.mask;
        end
        if (st_r.cnt == 3'h1) begin
          st_nxt.state = cbbc_pkg::cbbc_idle;
          st_nxt.busy  = 1'b0;
          st_nxt.done  = 1'b1;
          st_nxt.pc    = st_r.next_pc;
          if (st_r.op == cbbc_pkg::cbbc_op_bitinv) begin
            if (st_r.dest_status) begin
              // status word bits invert like any other destination
              st_nxt.stat_word = st_r.stat_word ^ st_r.mask;
            end else begin
              // carry result; zero mask leaves carry set
              st_nxt.stat_word = st_r.stat_word;
              st_nxt.stat_word[`CBBC_STAT_C] = st_r.carry_new;
            end
          end
        end else begin
          st_nxt.cnt = st_r.cnt - 3'h1;
        end
      end
      default: begin
        st_nxt.state = cbbc_pkg::cbbc_idle;
        st_nxt.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r           <= '0;
      st_r.pc        <= `CBBC_RST_PROG_CTR;
      st_r.stat_word <= `CBBC_RST_STAT_WORD;
      st_r.opmode    <= `CBBC_RST_OPMODE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ========================================================================
  // outputs
  assign busy      = st_r.busy;
  assign done      = st_r.done;
  assign taken     = st_r.taken;
  assign refused   = st_r.refused;
  assign mem_req   = st_r.mem;
  assign reg_rdata = st_r.reg_rdata;
  assign prog_ctr  = st_r.pc;
  assign stat_word = st_r.stat_word;

  // ========================================================================
  // checks; these assume no software write to the core state mid-instruction
  default clocking cbbc_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_taken_target:
    assert property (take && is_br && br_ok |-> ##6
                     (prog_ctr == $past(br_tgt, 6)) && done && taken)
    else $error("taken branch did not land on its target");

  a_target_sext:
    assert property (take && is_br && br_ok && instr.offset[6] |-> ##6
                     (prog_ctr < $past(prog_ctr, 6) + 16'h0001))
    else $error("negative displacement did not move backward");

  a_target_forward:
    assert property (take && is_br && br_ok && !instr.offset[6] |-> ##6
                     (prog_ctr == $past(prog_ctr, 6) + 16'h0001 +
                      {9'h000, $past(instr.offset, 6)}))
    else $error("positive displacement did not move forward");

  a_code_refused:
    assert property (take && is_br && (instr.cond > cbbc_pkg::cbbc_cc_uns_atmost)
                     |-> ##4 done && refused && !taken &&
                     (prog_ctr == $past(prog_ctr, 4) + 16'h0001))
    else $error("undefined condition code not refused");

  // a request seen while busy must not disturb the running instruction
  a_busy_ignored:
    assert property (busy |=> $stable(st_r.op) && $stable(st_r.mask) &&
                     $stable(st_r.next_pc))
    else $error("request accepted while busy");

  a_fall_through:
    assert property (take && is_br && !br_ok |-> ##4
                     done && !taken && (prog_ctr == $past(prog_ctr, 4) + 16'h0001))
    else $error("untaken branch did not step one word");

  a_taken_length:
    assert property (take && is_br && br_ok |=> !done [*5] ##1 done)
    else $error("taken branch length is not six cycles");

  a_fall_length:
    assert property (take && is_br && !br_ok |=> busy [*3] ##1 (done && !busy))
    else $error("untaken branch length is not four cycles");

  a_flags_kept:
    assert property (take && is_br |=> $stable(stat_word) [*6])
    else $error("branch altered the status word");

  a_zero_decode:
    assert property (take && is_br && (instr.cond == cbbc_pkg::cbbc_cc_zero_clear)
                     |-> (br_ok == !stat_word[`CBBC_STAT_Z]))
    else $error("zero-clear condition decoded wrong");

  a_signed_decode:
    assert property (take && is_br && (instr.cond == cbbc_pkg::cbbc_cc_signed_above)
                     |-> (br_ok == !(stat_word[`CBBC_STAT_Z] |
                          (stat_word[`CBBC_STAT_N] ^ stat_word[`CBBC_STAT_V]))))
    else $error("signed-above condition decoded wrong");

  a_alias_refused:
    assert property (take && is_br && is_alias(instr.cond) &&
                     !st_r.opmode[`CBBC_OPMODE_CC] |-> ##4 done && refused && !taken)
    else $error("unsigned alias accepted with mode bit clear");

  a_single_rmw:
    assert property (take && !is_br && !instr.dest_status |=> mem_req.rd
                     ##1 (!mem_req.rd && !mem_req.wr)
                     ##1 (mem_req.wr && !mem_req.rd &&
                          (mem_req.addr == $past(mem_req.addr, 2)))
                     ##1 (!mem_req.wr && done))
    else $error("bit invert access sequence wrong");

  a_invert_data:
    assert property (mem_req.wr |-> (mem_req.wdata == ($past(mem_rdata) ^ st_r.mask)))
    else $error("write-back data is not the inverted field");

  a_carry_result:
    assert property (mem_req.wr |=> (stat_word[`CBBC_STAT_C] ==
                     &($past(mem_rdata, 2) | ~st_r.mask)))
    else $error("carry does not reflect the tested field");

  a_zero_mask:
    assert property (mem_req.wr && (st_r.mask == 16'h0000) |->
                     (mem_req.wdata == $past(mem_rdata)) ##1 stat_word[`CBBC_STAT_C])
    else $error("empty mask changed destination or cleared carry");

  a_status_no_access:
    assert property (take && !is_br && instr.dest_status |=>
                     (!mem_req.rd && !mem_req.wr) [*4])
    else $error("status word destination touched memory");

  a_status_invert:
    assert property (take && !is_br && instr.dest_status |-> ##4
                     (stat_word == ($past(stat_word, 4) ^ $past(take_mask, 4))))
    else $error("status word bits not inverted by mask");

endmodule : cbbc_core

`default_nettype wire

// >>> cbbc_core_tb.sv
`timescale 1ns/1ns
`default_nettype none

module cbbc_core_tb;

  typedef struct packed {
    logic [3:0]  cond;
    logic [15:0] stat;
    logic        mode;
    logic [6:0]  off;
    logic        tk;
    logic        rf;
  } cbbc_row_s;

  logic                    ref_clk     = 1'h0;
  logic                    rst_b       = 1'h0;
  logic                    instr_valid = 1'h0;
  cbbc_pkg::cbbc_instr_s   instr       = '0;
  logic                    busy, done, taken, refused;
  cbbc_pkg::cbbc_mem_req_s mem_req;
  logic [15:0]             mem_rdata, reg_rdata, prog_ctr, stat_word, rv;
  logic [3:0]              reg_addr    = 4'h0;
  logic [15:0]             reg_wdata   = 16'h0000;
  logic                    reg_wr      = 1'h0;
  logic                    reg_rd      = 1'h0;
  int                      err_count   = 0;
  int                      checks_done = 0;
  int                      cyc, rd0, wr0, rd_count, wr_count;
  cbbc_pkg::cbbc_instr_s   ins;

  // ==========================================================================
  // branch table: condition, flags, alias mode, offset, taken, refused
  cbbc_row_s rows [19] = '{
    '{4'h0, 16'h0000, 1'h0, 7'h7f, 1'h1, 1'h0}, '{4'h1, 16'h0000, 1'h0, 7'h05, 1'h0, 1'h0},
    '{4'h2, 16'h0004, 1'h0, 7'h40, 1'h1, 1'h0}, '{4'h3, 16'h0004, 1'h0, 7'h05, 1'h0, 1'h0},
    '{4'h4, 16'h000a, 1'h0, 7'h3f, 1'h1, 1'h0}, '{4'h5, 16'h0008, 1'h0, 7'h02, 1'h1, 1'h0},
    '{4'h6, 16'h0000, 1'h0, 7'h02, 1'h1, 1'h0}, '{4'h6, 16'h0004, 1'h0, 7'h02, 1'h0, 1'h0},
    '{4'h7, 16'h0002, 1'h0, 7'h02, 1'h1, 1'h0}, '{4'h8, 16'h0010, 1'h0, 7'h02, 1'h1, 1'h0},
    '{4'h8, 16'h0000, 1'h0, 7'h02, 1'h0, 1'h0}, '{4'h9, 16'h0000, 1'h0, 7'h02, 1'h1, 1'h0},
    '{4'ha, 16'h0000, 1'h1, 7'h02, 1'h1, 1'h0}, '{4'hb, 16'h0001, 1'h1, 7'h02, 1'h1, 1'h0},
    '{4'hc, 16'h0001, 1'h1, 7'h02, 1'h0, 1'h0}, '{4'hc, 16'h0000, 1'h1, 7'h02, 1'h1, 1'h0},
    '{4'hd, 16'h0004, 1'h1, 7'h02, 1'h1, 1'h0}, '{4'ha, 16'h0000, 1'h0, 7'h02, 1'h0, 1'h1},
    '{4'he, 16'h0000, 1'h1, 7'h02, 1'h0, 1'h1}};

  always #5 ref_clk = ~ref_clk;

  cbbc_core cbbc_core_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
    .busy(busy), .done(done), .taken(taken), .refused(refused),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_ctr(prog_ctr),
    .stat_word(stat_word));

  cbbc_mem_model cbbc_mem_model_inst (
    .ref_clk(ref_clk), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .rd_count(rd_count), .wr_count(wr_count));

  // ==========================================================================
  // shared tasks
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic complete_run;
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge ref_clk);
    reg_wr    <= 1'h0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge ref_clk);
    reg_rd   <= 1'h0;
    #1 rv = reg_rdata;
  endtask : reg_read

  // one-cycle request, then count cycles from the first busy one until done shows
  task automatic run_op(input cbbc_pkg::cbbc_instr_s in);
    @(posedge ref_clk);
    instr       <= in;
    instr_valid <= 1'h1;
    @(posedge ref_clk);
    instr_valid <= 1'h0;
    // the cycle right after the take is cycle one of the instruction
    cyc = 1;
    while (cyc < 20) begin
      #1;
      if (done === 1'h1) break;
      @(posedge ref_clk);
      cyc++;
    end
  endtask : run_op

  task automatic bit_inv(input logic [15:0] a, d, m, st, exp_d, exp_st, input logic ds);
    reg_write(4'h0, 16'h0200);
    reg_write(4'h1, st);
    cbbc_mem_model_inst.mem[a[7:0]] = d;
    rd0 = rd_count;
    wr0 = wr_count;
    ins = '0;
    ins.op = cbbc_pkg::cbbc_op_bitinv;
    ins.mask = m;
    ins.addr = a;
    ins.dest_status = ds;
    run_op(ins);
    check("bit cycles", 16'h0004, 16'(cyc));
    check("bit pc", 16'h0202, prog_ctr);
    check("bit mem", exp_d, cbbc_mem_model_inst.mem[a[7:0]]);
    check("bit status", exp_st, stat_word);
    check("bit reads", {15'h0, ~ds}, 16'(rd_count - rd0));
    check("bit writes", {15'h0, ~ds}, 16'(wr_count - wr0));
  endtask : bit_inv

  // ==========================================================================
  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    check("reset pc", 16'h0000, prog_ctr);
    check("reset status", 16'h0000, stat_word);
    check("reset busy", 16'h0000, {15'h0, busy});
    @(posedge ref_clk);
    rst_b <= 1'h1;
    reg_read(4'h2);
    check("opmode", 16'h0000, rv);
    reg_read(4'hf);
    check("unmapped", 16'h0000, rv);
    foreach (rows[i]) begin
      reg_write(4'h0, 16'h0100);
      reg_write(4'h1, rows[i].stat);
      reg_write(4'h2, {7'h00, rows[i].mode, 8'h00});
      ins = '0;
      ins.op = cbbc_pkg::cbbc_op_branch;
      ins.cond = cbbc_pkg::cbbc_cond_e'(rows[i].cond);
      ins.offset = rows[i].off;
      run_op(ins);
      check("br cycles", rows[i].tk ? 16'h0006 : 16'h0004, 16'(cyc));
      check("br pc", rows[i].tk ? 16'h0101 + {{9{rows[i].off[6]}}, rows[i].off}
                                : 16'h0101, prog_ctr);
      check("br taken", {15'h0, rows[i].tk}, {15'h0, taken});
      check("br refused", {15'h0, rows[i].rf}, {15'h0, refused});
      check("br status", rows[i].stat, stat_word);
    end
    reg_read(4'h3);
    check("exec status", 16'h0002, rv);
    bit_inv(16'h0012, 16'h0010, 16'h0310, 16'h0001, 16'h0300, 16'h0000, 1'h0);
    bit_inv(16'h0013, 16'hffff, 16'h8001, 16'h0000, 16'h7ffe, 16'h0001, 1'h0);
    bit_inv(16'h0014, 16'h5a5a, 16'h0000, 16'h0006, 16'h5a5a, 16'h0007, 1'h0);
    bit_inv(16'h0015, 16'h1234, 16'h0021, 16'h0005, 16'h1234, 16'h0024, 1'h1);
    // requests held up while busy must be dropped
    reg_write(4'h0, 16'h0100);
    reg_write(4'h1, 16'h0000);
    ins = '0;
    ins.offset = 7'h03;
    wr0 = wr_count;
    @(posedge ref_clk);
    instr       <= ins;
    instr_valid <= 1'h1;
    @(posedge ref_clk);
    ins.op      = cbbc_pkg::cbbc_op_bitinv;
    instr       <= ins;
    repeat (2) @(posedge ref_clk);
    instr_valid <= 1'h0;
    #1;
    check("busy hold", 16'h0001, {15'h0, busy});
    repeat (3) @(posedge ref_clk);
    #1;
    check("busy done", 16'h0001, {15'h0, done});
    check("busy pc", 16'h0104, prog_ctr);
    check("busy writes", 16'h0000, 16'(wr_count - wr0));
    // reset in mid-instruction abandons it, no write-back afterwards
    ins.addr = 16'h0016;
    wr0 = wr_count;
    @(posedge ref_clk);
    instr       <= ins;
    instr_valid <= 1'h1;
    @(posedge ref_clk);
    instr_valid <= 1'h0;
    @(posedge ref_clk);
    rst_b <= 1'h0;
    @(posedge ref_clk);
    #1;
    check("mid reset busy", 16'h0000, {15'h0, busy});
    check("mid reset pc", 16'h0000, prog_ctr);
    check("mid reset status", 16'h0000, stat_word);
    @(posedge ref_clk);
    rst_b <= 1'h1;
    repeat (4) @(posedge ref_clk);
    #1;
    check("mid reset writes", 16'h0000, 16'(wr_count - wr0));
    check("mid reset done", 16'h0000, {15'h0, done});
    complete_run();
  end

  // ==========================================================================
  // watchdog: the whole sequence needs well under this many cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_count++;
    complete_run();
  end

endmodule : cbbc_core_tb

`default_nettype wire

// >>> cbbc_defines.svh
`ifndef CBBC_DEFINES_SVH
`define CBBC_DEFINES_SVH

// ==========================================================================
// register port offsets (word index)
`define CBBC_OFS_PROG_CTR   4'h0
`define CBBC_OFS_STAT_WORD  4'h1
`define CBBC_OFS_OPMODE     4'h2
`define CBBC_OFS_EXEC_STAT  4'h3

// ==========================================================================
// status word field positions
`define CBBC_STAT_C         0
`define CBBC_STAT_V         1
`define CBBC_STAT_Z         2
`define CBBC_STAT_N         3
`define CBBC_STAT_U         4
`define CBBC_STAT_E         5

// operating mode: unsigned condition aliases allowed
`define CBBC_OPMODE_CC      8

// execution status read-back positions
`define CBBC_XST_TAKEN      0
`define CBBC_XST_REFUSED    1
`define CBBC_XST_BUSY       2

// ==========================================================================
// reset values
`define CBBC_RST_PROG_CTR   16'h0000
`define CBBC_RST_STAT_WORD  16'h0000
`define CBBC_RST_OPMODE     16'h0000

// ==========================================================================
// timing in core clock cycles and program words
`define CBBC_CYC_BR_TAKEN   3'h6
`define CBBC_CYC_BR_FALL    3'h4
`define CBBC_CYC_BITINV     3'h4
`define CBBC_WORDS_BR       16'h0001
`define CBBC_WORDS_BITINV   16'h0002

`endif

// >>> cbbc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// data memory behind the core; answers every read in the next cycle
module cbbc_mem_model (
  // clock
  input  wire logic                    ref_clk,
  // request from the core
  input  wire cbbc_pkg::cbbc_mem_req_s mem_req,
  // answer and access counts
  output logic [15:0]                  mem_rdata,
  output int                           rd_count,
  output int                           wr_count
);

  logic [15:0] mem [256];

  initial begin
    mem_rdata = 16'h0000;
    rd_count  = 0;
    wr_count  = 0;
  end

  // ==========================================================================
  // read data valid one cycle only; toggled otherwise so a late sample shows
  always @(posedge ref_clk) begin
    if (mem_req.rd) begin
      mem_rdata <= mem[mem_req.addr[7:0]];
      rd_count  <= rd_count + 1;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_req.wr) begin
      mem[mem_req.addr[7:0]] <= mem_req.wdata;
      wr_count               <= wr_count + 1;
    end
  end

endmodule : cbbc_mem_model

`default_nettype wire

// >>> cbbc_pkg.sv
`default_nettype none

// ==========================================================================
// shared types of the branch / bit-invert execution block
package cbbc_pkg;

  typedef enum logic [0:0] {
    cbbc_idle = 1'b0,
    cbbc_run  = 1'b1
  } cbbc_state_e;

  typedef enum logic [0:0] {
    cbbc_op_branch = 1'b0,
    cbbc_op_bitinv = 1'b1
  } cbbc_op_e;

  typedef enum logic [3:0] {
    cbbc_cc_carry_clr     = 4'h0,
    cbbc_cc_carry_set     = 4'h1,
    cbbc_cc_zero_set      = 4'h2,
    cbbc_cc_zero_clear    = 4'h3,
    cbbc_cc_signed_atleast = 4'h4,
    cbbc_cc_signed_under  = 4'h5,
    cbbc_cc_signed_above  = 4'h6,
    cbbc_cc_signed_atmost = 4'h7,
    cbbc_cc_not_normal    = 4'h8,
    cbbc_cc_normal        = 4'h9,
    cbbc_cc_uns_not_under = 4'ha,
    cbbc_cc_uns_under     = 4'hb,
    cbbc_cc_uns_above     = 4'hc,
    cbbc_cc_uns_atmost    = 4'hd
  } cbbc_cond_e;

  typedef struct packed {
    cbbc_op_e    op;
    cbbc_cond_e  cond;
    logic [6:0]  offset;
    logic [15:0] mask;
    logic        dest_status;
    logic [15:0] addr;
  } cbbc_instr_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cbbc_mem_req_s;

  typedef struct packed {
    cbbc_state_e   state;
    logic [2:0]    cnt;
    cbbc_op_e      op;
    logic          dest_status;
    logic [15:0]   mask;
    logic [15:0]   next_pc;
    logic          carry_new;
    logic [15:0]   pc;
    logic [15:0]   stat_word;
    logic [15:0]   opmode;
    logic          busy;
    logic          done;
    logic          taken;
    logic          refused;
    cbbc_mem_req_s mem;
    logic [15:0]   reg_rdata;
  } cbbc_st_s;

endpackage : cbbc_pkg

`default_nettype wire
